// ### pcm_regs.vh
// Purpose: Constants for the PCI configuration mapping block
// Assumes: Config offsets are standard PCI header dword offsets, chosen here
// Notes: Included by pcm_top.v and pcm_lat_timer.v
`ifndef PCM_REGS_VH
`define PCM_REGS_VH

// Config space byte offsets (low 8 bits of config address)
`define PCM_OFF_CMD_STATUS 8'h04
`define PCM_OFF_LAT_TIMER 8'h0C
`define PCM_OFF_MEM_BASE 8'h10
`define PCM_OFF_INT_ROUTE 8'h3C

// Command/status fields
`define PCM_CMD_MEM_EN 1
`define PCM_CMD_MST_EN 2

// Base-address fields
`define PCM_BAR_HI 31
`define PCM_BAR_LO 27
`define PCM_BAR_IO_BIT 0

// Latency timer field
`define PCM_LAT_HI 15
`define PCM_LAT_LO 8
`define PCM_LAT_W 8

// Interrupt-line field
`define PCM_INTL_HI 7
`define PCM_INTL_LO 0

// One-hot select bits for the config registers
`define PCM_SEL_CMD 0
`define PCM_SEL_LAT 1
`define PCM_SEL_BAR 2
`define PCM_SEL_INT 3

// Reset values
`define PCM_RST_32 32'h0000_0000
`define PCM_RST_8 8'h00
`define PCM_RST_5 5'h00

`endif

// ### pcm_lat_timer.v
// Purpose: Bus-ownership latency counter for the master side
// Assumes: gnt and own are synchronous to clk
// Notes: Loads on grant, counts down while owning the bus
`timescale 1ns/1ns

`include "pcm_regs.vh"

module pcm_lat_timer #(
   parameter W = `PCM_LAT_W
) (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire [W-1:0] limit,
   input wire gnt_start,
   input wire own,
   output wire expired
);

   reg [W-1:0] cnt_ff;
   reg exp_ff;
   reg [W-1:0] nxt_cnt;
   reg nxt_exp;

   always @* begin
      nxt_cnt = cnt_ff;
      nxt_exp = exp_ff;
      if (gnt_start) begin
         nxt_cnt = limit;
         nxt_exp = (limit == {W{1'b0}});
      end else if (own && !exp_ff) begin
         if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
            nxt_cnt = {W{1'b0}};
            nxt_exp = 1'b1;
         end else begin
            nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
         end
      end else if (!own) begin
         nxt_exp = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         cnt_ff <= {W{1'b0}};
         exp_ff <= 1'b0;
      end else if (ce) begin
         cnt_ff <= nxt_cnt;
         exp_ff <= nxt_exp;
      end
   end

   assign expired = exp_ff;

endmodule // pcm_lat_timer

// ### pcm_top.v
// Purpose: PCI configuration registers, memory decode and master gating
// Assumes: One config access per cfg_valid pulse; all inputs synchronous to clk
// Notes: Read data, hit and ownership outputs are registered (one cycle late)
`timescale 1ns/1ns

`include "pcm_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - The base register keeps the device's memory base in bits 31 to 27.
// - Memory accesses are answered only while memory-space enable is set.
// - After an all-ones write the base reads zeros in bits 26 to 4 (128MB needed).
// - Base bit 0 always reads zero, so the device lives in memory space.
// - With base set and memory enable on, the device acts as a normal target.
// - Bus ownership lasts one clock more than the count in latency-timer bits 15 to 8, or longer while still granted.
// - The device masters the bus only while master enable is set.
// - The interrupt-line value reads back unchanged.
module pcm_top #(
   parameter LAT_W = `PCM_LAT_W
) (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire cfg_valid,
   input wire cfg_write,
   input wire [7:0] cfg_addr,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   output reg [31:0] cfg_rdata_ff,
   output reg cfg_rvalid_ff,
   input wire mem_valid,
   input wire [31:0] mem_addr,
   output reg mem_hit_ff,
   input wire dma_req,
   input wire bus_gnt,
   output reg bus_req_ff,
   output reg bus_own_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   // Only base bits 31:27 are stored; the lower bits read as zero
   reg [`PCM_BAR_HI:`PCM_BAR_LO] base_ff;
   reg mem_en_ff;
   reg mst_en_ff;
   reg [LAT_W-1:0] lat_ff;
   reg [7:0] intl_ff;
   reg gnt_d_ff;

   // Byte-lane merge, used for every writable register
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge[i*8 +: 8] = wd[i*8 +: 8];
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register select, shared by the write and read paths
   function [3:0] reg_sel;
      input [7:0] a;
      begin
         reg_sel = 4'h0;
         reg_sel[`PCM_SEL_CMD] = (a == `PCM_OFF_CMD_STATUS);
         reg_sel[`PCM_SEL_LAT] = (a == `PCM_OFF_LAT_TIMER);
         reg_sel[`PCM_SEL_BAR] = (a == `PCM_OFF_MEM_BASE);
         reg_sel[`PCM_SEL_INT] = (a == `PCM_OFF_INT_ROUTE);
      end
   endfunction

   wire wr = cfg_valid && cfg_write;
   wire [3:0] sel = reg_sel(cfg_addr);
   wire [31:0] cur_cmd = {29'h0000_0000, mst_en_ff, mem_en_ff, 1'b0};
   // Built by part-select so the field stays at bit 8 for any timer width
   reg [31:0] cur_lat;
   always @* begin
      cur_lat = `PCM_RST_32;
      cur_lat[`PCM_LAT_LO +: LAT_W] = lat_ff;
   end
   // Bits 26:0 are hardwired zero, so an all-ones probe reads 128MB-aligned size
   wire [31:0] cur_bar = {base_ff, 27'h000_0000};
   wire [31:0] cur_int = {24'h00_0000, intl_ff};
   wire [31:0] m_cmd = merge(cur_cmd, cfg_wdata, cfg_be);
   wire [31:0] m_lat = merge(cur_lat, cfg_wdata, cfg_be);
   wire [31:0] m_bar = merge(cur_bar, cfg_wdata, cfg_be);
   wire [31:0] m_int = merge(cur_int, cfg_wdata, cfg_be);

   ////////////////////////////////////////////////////////////////////////////
   // Config writes
   always @(posedge clk) begin
      if (srst) begin
         base_ff <= `PCM_RST_5;
         mem_en_ff <= 1'b0;
         mst_en_ff <= 1'b0;
         lat_ff <= {LAT_W{1'b0}};
         intl_ff <= `PCM_RST_8;
      end else if (ce && wr) begin
         // Unmapped offsets match no select, so the write is dropped
         if (sel[`PCM_SEL_CMD]) begin
            mem_en_ff <= m_cmd[`PCM_CMD_MEM_EN];
            mst_en_ff <= m_cmd[`PCM_CMD_MST_EN];
         end
         if (sel[`PCM_SEL_LAT]) begin
            lat_ff <= m_lat[`PCM_LAT_LO +: LAT_W];
         end
         if (sel[`PCM_SEL_BAR]) begin
            base_ff <= m_bar[`PCM_BAR_HI:`PCM_BAR_LO];
         end
         if (sel[`PCM_SEL_INT]) begin
            intl_ff <= m_int[`PCM_INTL_HI:`PCM_INTL_LO];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Config reads; unmapped offsets read zero
   reg [31:0] nxt_rdata;
   always @* begin
      nxt_rdata = `PCM_RST_32;
      if (sel[`PCM_SEL_CMD]) begin
         nxt_rdata = cur_cmd;
      end
      if (sel[`PCM_SEL_LAT]) begin
         nxt_rdata = cur_lat;
      end
      if (sel[`PCM_SEL_BAR]) begin
         nxt_rdata = cur_bar;
      end
      if (sel[`PCM_SEL_INT]) begin
         nxt_rdata = cur_int;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         cfg_rdata_ff <= `PCM_RST_32;
         cfg_rvalid_ff <= 1'b0;
      end else if (ce) begin
         cfg_rvalid_ff <= cfg_valid && !cfg_write;
         // Data holds between reads; only rvalid pulses
         if (cfg_valid && !cfg_write) begin
            cfg_rdata_ff <= nxt_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory target decode
   // Only the stored base bits are compared; the rest is the window offset
   wire nxt_hit = mem_valid && mem_en_ff
                  && (mem_addr[`PCM_BAR_HI:`PCM_BAR_LO] == base_ff);

   always @(posedge clk) begin
      if (srst) begin
         mem_hit_ff <= 1'b0;
      end else if (ce) begin
         mem_hit_ff <= nxt_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus mastering
   wire lat_expired;
   // A regrant while owning must not reload the timer and stretch the limit
   wire gnt_start = bus_gnt && !gnt_d_ff && bus_req_ff && !bus_own_ff;

   // Timer shares ce, so a frozen block also freezes the count
   pcm_lat_timer #(
      .W(LAT_W)
   ) pcm_lat_timer_inst (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .limit(lat_ff),
      .gnt_start(gnt_start),
      .own(bus_own_ff),
      .expired(lat_expired)
   );

   // Hold ownership past expiry while still granted, as PCI allows
   // The drop is registered, so ownership ends one cycle after expiry
   wire release_bus = lat_expired && !bus_gnt;

   reg nxt_own;
   always @* begin
      nxt_own = bus_own_ff;
      if (!mst_en_ff || !dma_req) begin
         nxt_own = 1'b0;
      end else if (gnt_start) begin
         nxt_own = 1'b1;
      end else if (release_bus) begin
         nxt_own = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         gnt_d_ff <= 1'b0;
         bus_req_ff <= 1'b0;
         bus_own_ff <= 1'b0;
      end else if (ce) begin
         gnt_d_ff <= bus_gnt;
         bus_req_ff <= dma_req && mst_en_ff;
         bus_own_ff <= nxt_own;
      end
   end

endmodule // pcm_top

// ### pcm_monitor.sv
// Purpose: Port checker for pcm_top
// Assumes: checks pause while ce is low
// Notes: Shadows enables and base from config writes
`timescale 1ns/1ns
module pcm_chk (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire cfg_valid,
   input wire cfg_write,
   input wire [7:0] cfg_addr,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   input wire [31:0] cfg_rdata_ff,
   input wire cfg_rvalid_ff,
   input wire mem_valid,
   input wire [31:0] mem_addr,
   input wire mem_hit_ff,
   input wire dma_req,
   input wire bus_gnt,
   input wire bus_req_ff,
   input wire bus_own_ff
);
   reg men_ff, mst_ff;
   reg [4:0] base_ff;
   wire wr = cfg_valid & cfg_write;
   always @(posedge clk) begin
      if (srst) {men_ff, mst_ff, base_ff} <= 7'h00;
      if (!srst && ce && wr && cfg_addr == 8'h04 && cfg_be[0]) {mst_ff, men_ff} <= cfg_wdata[2:1];
      if (!srst && ce && wr && cfg_addr == 8'h10 && cfg_be[3]) base_ff <= cfg_wdata[31:27];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst || !ce);
   a_read_answer: assert property (cfg_valid && !cfg_write |=> cfg_rvalid_ff) else $error("no rvalid");
   a_write_silent: assert property (wr |=> !cfg_rvalid_ff) else $error("rvalid on write");
   a_base_read: assert property (
      cfg_rvalid_ff && $past(cfg_addr) == 8'h10 |-> cfg_rdata_ff == {base_ff, 27'h0})
      else $error("base read");
   a_hit_decode: assert property (
      mem_valid |-> ##1 mem_hit_ff == $past(men_ff && mem_addr[31:27] == base_ff))
      else $error("bad hit");
   a_hit_idle: assert property (!mem_valid |=> !mem_hit_ff) else $error("stray hit");
   a_req_gate: assert property (1 |=> bus_req_ff == $past(dma_req && mst_ff)) else $error("req");
   a_own_grant: assert property (
      $rose(bus_own_ff) |-> $past(bus_req_ff && bus_gnt))
      else $error("own w/o grant");
   a_own_drop: assert property (!dma_req || !mst_ff |=> !bus_own_ff) else $error("own held");
   c_read: cover property (cfg_rvalid_ff);
   c_hit: cover property (mem_hit_ff);
   c_own_end: cover property ($fell(bus_own_ff));
endmodule // pcm_chk
bind pcm_top pcm_chk pcm_chk_inst (.*);

// ### pcm_arb_model.sv
// Purpose: Arbiter stand-in for the bus request
// Assumes: req is the registered request
// Notes: One grant per request, after dly cycles, for hold cycles
`timescale 1ns/1ns
module pcm_arb_model (
   input wire clk,
   input wire srst,
   input wire req,
   input wire [7:0] dly,
   input wire [7:0] hold,
   output wire gnt
);
   reg [8:0] cnt_ff;
   always @(posedge clk) begin
      if (srst || !req) cnt_ff <= 9'h000;
      else if (!cnt_ff[8]) cnt_ff <= cnt_ff + 9'h001;
   end
   assign gnt = req && cnt_ff >= dly && cnt_ff < dly + hold;
endmodule // pcm_arb_model

// ### test_pci_config_mapping.sv
// Purpose: Self-checking bench for pcm_top
// Assumes: ce low only around the frozen-write scenario
// Notes: Config reads are checked in order from a queue
`timescale 1ns/1ns
module test_pci_config_mapping;
   reg clk = 1'b0, srst = 1'b1, ce = 1'b1, cfg_valid = 1'b0, cfg_write = 1'b0;
   reg mem_valid = 1'b0, dma_req = 1'b0;
   reg [7:0] cfg_addr = 8'h00, dly = 8'h00, hold = 8'h00;
   reg [3:0] cfg_be = 4'h0;
   reg [31:0] cfg_wdata = 32'h0000_0000, mem_addr = 32'h0000_0000, r;
   wire [31:0] cfg_rdata_ff;
   wire cfg_rvalid_ff, mem_hit_ff, bus_req_ff, bus_own_ff, bus_gnt;
   integer err_total = 0, cmp_count = 0, seed = 32'h0ca8, i, n;
   reg [63:0] q[$];
   reg [63:0] e;
   pcm_top pcm_top_inst (.clk, .srst, .ce, .cfg_valid, .cfg_write, .cfg_addr, .cfg_be,
      .cfg_wdata, .cfg_rdata_ff, .cfg_rvalid_ff, .mem_valid, .mem_addr, .mem_hit_ff,
      .dma_req, .bus_gnt, .bus_req_ff, .bus_own_ff);
   pcm_arb_model pcm_arb_model_inst (.clk, .srst, .req(bus_req_ff), .dly, .hold, .gnt(bus_gnt));
   task chk(input string nm, input [31:0] s, input [31:0] x);
      cmp_count++;
      if (s !== x) err_total++;
      if (s !== x) $display("ERROR %s exp %h seen %h", nm, x, s);
   endtask
   task end_sim;
      chk("pending_reads", q.size(), 0);
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cfg(input w, input [7:0] a, input [3:0] b, input [31:0] d, input [63:0] x);
      @(posedge clk);
      {cfg_valid, cfg_write, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, w, a, b, d};
      if (!w) q.push_back(x);
      @(posedge clk);
      cfg_valid <= 1'b0;
   endtask
   task mem(input [31:0] a, input h);
      @(posedge clk);
      {mem_valid, mem_addr} <= {1'b1, a};
      @(posedge clk);
      mem_valid <= 1'b0;
      @(negedge clk);
      chk("hit", mem_hit_ff, h);
   endtask
   // Own length: one more than the timer limit, or grant length, whichever is longer
   task dma(input [7:0] d, input [7:0] h, input [7:0] lo);
      @(posedge clk);
      {dly, hold, dma_req} <= {d, h, 1'b1};
      for (i = 0; i < 50 && bus_own_ff !== 1'b1; i++) @(negedge clk);
      for (n = 0; n < 300 && bus_own_ff === 1'b1; n++) @(negedge clk);
      chk("own_len", n >= lo && n <= lo + 2, 1);
      @(posedge clk);
      dma_req <= 1'b0;
   endtask
   always @(negedge clk) begin
      if (cfg_rvalid_ff === 1'b1) begin
         if (q.size() == 0) begin
            chk("rvalid", 1, 0);
         end else begin
            e = q.pop_front();
            chk("rdata", cfg_rdata_ff & e[63:32], e[31:0]);
         end
      end
   end
   initial forever #2 clk = ~clk;
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      cfg(1, 8'h10, 4'hf, 32'hffff_ffff, 0);
      cfg(0, 8'h10, 4'hf, 0, {32'hffff_ffff, 32'hf800_0000});
      cfg(0, 8'h20, 4'hf, 0, {32'hffff_ffff, 32'h0000_0000});
      r = $random(seed);
      cfg(1, 8'h10, 4'hf, r, 0);
      cfg(0, 8'h10, 4'hf, 0, {32'hffff_ffff, r[31:27], 27'h0});
      // A write while ce is low must not land
      @(posedge clk);
      ce <= 1'b0;
      cfg(1, 8'h10, 4'hf, ~r, 0);
      ce <= 1'b1;
      cfg(0, 8'h10, 4'hf, 0, {32'hffff_ffff, r[31:27], 27'h0});
      mem(r, 1'b0);
      cfg(1, 8'h04, 4'h1, 32'h0000_0002, 0);
      cfg(0, 8'h04, 4'hf, 0, {32'hffff_ffff, 32'h0000_0002});
      mem(r ^ 32'h07ff_ffff, 1'b1);
      mem(r ^ 32'h0800_0000, 1'b0);
      for (i = 0; i < 3; i++) begin
         r = $random(seed);
         cfg(1, 8'h3c, 4'h1, r, 0);
         cfg(0, 8'h3c, 4'hf, 0, {32'h0000_00ff, 24'h00_0000, r[7:0]});
      end
      // Request with master enable still clear must stay off
      @(posedge clk);
      dma_req <= 1'b1;
      repeat (4) @(negedge clk);
      chk("req", bus_req_ff, 0);
      cfg(1, 8'h0c, 4'h2, 32'h0000_0400, 0);
      cfg(0, 8'h0c, 4'hf, 0, {32'h0000_ff00, 32'h0000_0400});
      cfg(1, 8'h04, 4'h1, 32'h0000_0006, 0);
      dma(8'h02, 8'h01, 8'h04);
      dma(8'h05, 8'h0c, 8'h0c);
      // Clearing master enable mid-ownership drops the bus next cycle
      @(posedge clk);
      {dly, hold, dma_req} <= {8'h01, 8'h28, 1'b1};
      for (i = 0; i < 50 && bus_own_ff !== 1'b1; i++) @(negedge clk);
      chk("own_on", bus_own_ff, 1);
      cfg(1, 8'h04, 4'h1, 32'h0000_0002, 0);
      repeat (2) @(negedge clk);
      chk("own_off", bus_own_ff, 0);
      chk("req_off", bus_req_ff, 0);
      @(posedge clk);
      dma_req <= 1'b0;
      end_sim;
   end
endmodule // test_pci_config_mapping
